// [src/split_desc_regs.svh]
// Offsets, field positions and reset values of the split descriptor engine.
`ifndef SPLIT_DESC_REGS_SVH
`define SPLIT_DESC_REGS_SVH
// Descriptor words sit at byte address 4 * word index.
`define DESC_WORDS 8
`define CTRL_OFFSET 8'h20
`define STAT_OFFSET 8'h24
`define CTRL_RESET 32'h0000_0000
`define CTRL_ENABLE_BIT 0
// Lowest word: endpoint low bit, payload limit, byte count, valid.
`define W0_ENDPOINT_BIT 31
`define W0_LIMIT_LSB 18
`define W0_COUNT_LSB 3
`define W0_VALID_BIT 0
// Third word: buffer start pointer above frame select.
`define W2_POINTER_LSB 8
`define W2_FRAME_LSB 3
// Fourth word: active, split phase, bytes transferred.
`define W3_ACTIVE_BIT 31
`define W3_PHASE_BIT 27
`define W3_DONE_LSB 0
// Fifth word: per-microframe results above the start split mask.
`define W4_RESULT_LSB 8
`define W4_SS_MASK_LSB 0
// Sixth word: complete split mask; counts start in its second byte.
`define W5_CS_MASK_LSB 0
`define COUNT_FIRST_WORD 5
`define RESULT_FATAL_BIT 2
`endif

// [src/split_desc_pkg.sv]
// Types shared by the split descriptor engine and its users.
`default_nettype none
package split_desc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_START = 2'b01,
        ST_WAIT_COMPLETE = 2'b11
    } sched_state_e;

    // One split transaction handed to the link layer.
    typedef struct packed {
        logic valid;
        logic complete;
        logic endpoint_low;
        logic [10:0] len;
        logic [15:0] buffer_start_pointer;
    } txn_req_s;

    // Outcome of one split transaction from the link layer.
    typedef struct packed {
        logic valid;
        logic [2:0] uframe_result;
        logic [7:0] bytes;
    } txn_res_s;
endpackage : split_desc_pkg
`default_nettype wire

// [src/split_descriptor_engine.sv]
// Scheduler and storage for one start/complete split transfer descriptor.
//
// Implementation choices: the register addresses and the plain strobed port.
`include "split_desc_regs.svh"
`default_nettype none
module split_descriptor_engine
    import split_desc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic uframe_tick_in,
    input wire logic [2:0] uframe_in,
    input wire logic [4:0] frame_in,
    output txn_req_s req_out,
    input wire txn_res_s res_in,
    output logic active_out
);
    logic [31:0] desc_mem [`DESC_WORDS];
    logic [31:0] hw_img [`DESC_WORDS];
    logic [31:0] ctrl_reg;
    logic [31:0] rdata_reg;
    sched_state_e state_reg;
    sched_state_e state_next;
    txn_req_s req_reg;
    logic [2:0] uf_reg;
    logic ss_hit_reg;

    // Field views of the lowest, third, fourth, fifth and sixth words.
    wire desc_valid = desc_mem[0][`W0_VALID_BIT];
    wire [10:0] split_payload_limit = desc_mem[0][`W0_LIMIT_LSB +: 11];
    wire [14:0] buffer_byte_count = desc_mem[0][`W0_COUNT_LSB +: 15];
    wire [15:0] buffer_start_pointer = desc_mem[2][`W2_POINTER_LSB +: 16];
    wire [4:0] frame_select = desc_mem[2][`W2_FRAME_LSB +: 5];
    wire [11:0] bytes_done = desc_mem[3][`W3_DONE_LSB +: 12];
    wire [7:0] start_split_mask = desc_mem[4][`W4_SS_MASK_LSB +: 8];
    wire [7:0] complete_split_mask = desc_mem[5][`W5_CS_MASK_LSB +: 8];

    // Bytes still owed; the limit caps each start split.
    wire [14:0] bytes_left = buffer_byte_count - {3'h0, bytes_done};
    wire limit_wins = bytes_left >= {4'h0, split_payload_limit};
    wire [10:0] ss_len = limit_wins ? split_payload_limit :
        bytes_left[10:0];
    wire frame_hit = frame_select == frame_in;

    // Decide what this microframe tick launches, if anything.
    wire launch_ok = uframe_tick_in && ctrl_reg[`CTRL_ENABLE_BIT] &&
        state_reg == ST_IDLE && desc_valid;
    wire ss_go = launch_ok && start_split_mask[uframe_in] && frame_hit;
    wire cs_go = launch_ok && complete_split_mask[uframe_in] && !ss_go;
    wire res_take = res_in.valid && state_reg != ST_IDLE;
    wire fatal = res_in.uframe_result[`RESULT_FATAL_BIT];

    // Counts run over words five to seven, one byte per microframe.
    wire [3:0] cnt_slot = {1'b0, uf_reg} + 4'h1;
    wire [2:0] cnt_word = 3'(`COUNT_FIRST_WORD) + {1'b0, cnt_slot[3:2]};
    wire [4:0] cnt_bit = {cnt_slot[1:0], 3'h0};
    wire [11:0] done_sum = bytes_done + {4'h0, res_in.bytes};
    wire finished = {3'h0, done_sum} >= buffer_byte_count;

    // Register decode on the plain port.
    wire [5:0] word_sel = addr_in[7:2];
    wire mem_hit = addr_in[1:0] == 2'h0 && word_sel < 6'(`DESC_WORDS);
    wire ctrl_hit = addr_in == `CTRL_OFFSET;
    wire stat_hit = addr_in == `STAT_OFFSET;
    wire [31:0] stat_word = {29'h0, desc_valid, state_reg};
    wire [31:0] rd_mux = mem_hit ? desc_mem[word_sel[2:0]] :
        ctrl_hit ? ctrl_reg : stat_hit ? stat_word : 32'h0000_0000;

    // Hardware image of the descriptor after the current result lands.
    always_comb begin
        hw_img = desc_mem;
        if (res_take) begin
            hw_img[4][`W4_RESULT_LSB + 3 * uf_reg +: 3] =
                res_in.uframe_result;
            if (ss_hit_reg) begin
                hw_img[cnt_word][cnt_bit +: 8] = res_in.bytes;
            end
            hw_img[3][`W3_DONE_LSB +: 12] = done_sum;
            if (state_reg == ST_WAIT_COMPLETE) begin
                hw_img[5][`W5_CS_MASK_LSB + uf_reg] = 1'b0;
                hw_img[3][`W3_PHASE_BIT] = 1'b0;
            end else begin
                hw_img[3][`W3_PHASE_BIT] = 1'b1;
            end
            if (finished || fatal) begin
                hw_img[0][`W0_VALID_BIT] = 1'b0;
                hw_img[3][`W3_ACTIVE_BIT] = 1'b0;
            end
        end
    end

    // Each word takes a software write over the hardware image.
    for (genvar w = 0; w < `DESC_WORDS; w++) begin : g_word
        wire sw_wr = wr_in && mem_hit && word_sel[2:0] == 3'(w);
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                desc_mem[w] <= 32'h0000_0000;
            end else begin
                desc_mem[w] <= sw_wr ? wdata_in : hw_img[w];
            end
        end
    end

    // Waiting states hold until the link layer answers.
    always_comb begin
        case (state_reg)
            ST_IDLE: begin
                state_next = ss_go ? ST_WAIT_START :
                    cs_go ? ST_WAIT_COMPLETE : ST_IDLE;
            end
            ST_WAIT_START,
            ST_WAIT_COMPLETE: begin
                state_next = res_in.valid ? ST_IDLE : state_reg;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Request is held stable from launch until the answer is taken.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            uf_reg <= 3'h0;
            ss_hit_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (ss_go || cs_go) begin
                req_reg.valid <= 1'b1;
                req_reg.complete <= cs_go;
                req_reg.endpoint_low <= desc_mem[0][`W0_ENDPOINT_BIT];
                req_reg.len <= cs_go ? 11'h000 : ss_len;
                req_reg.buffer_start_pointer <= buffer_start_pointer;
                uf_reg <= uframe_in;
                ss_hit_reg <= start_split_mask[uframe_in] && frame_hit;
            end else if (res_take) begin
                req_reg.valid <= 1'b0;
            end
        end
    end

    // Control register and registered read data.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_reg <= `CTRL_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_in && ctrl_hit) begin
                ctrl_reg <= {31'h0, wdata_in[`CTRL_ENABLE_BIT]};
            end
            rdata_reg <= rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    assign rdata_out = rdata_reg;
    assign req_out = req_reg;
    assign active_out = desc_valid;

    // Checks; a software write into the same word excuses a change.
    wire [7:0] cnt_now = desc_mem[cnt_word][cnt_bit +: 8];
    wire wr_w0 = wr_in && mem_hit && word_sel[2:0] == 3'h0;
    wire wr_cnt = wr_in && mem_hit && word_sel[2:0] == cnt_word;

    sequence s_answer;
        res_take && !wr_in;
    endsequence

    sequence s_waiting;
        req_out.valid && !res_in.valid;
    endsequence

    a_launch_needs_valid: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(req_out.valid) |-> $past(desc_valid) &&
            $past(ctrl_reg[`CTRL_ENABLE_BIT]))
        else $error("Request launched for an invalid descriptor.");

    a_start_len_capped: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(req_out.valid) && !req_out.complete |->
            req_out.len == $past(ss_len) &&
            req_out.len <= $past(split_payload_limit))
        else $error("Start split length exceeds the payload limit.");

    a_valid_on_done: assert property (
        @(posedge clk_in) disable iff (reset_in)
        s_answer ##0 (finished || fatal) |=> !desc_valid && !active_out)
        else $error("Valid bit not cleared at completion or fatal error.");

    a_valid_kept: assert property (
        @(posedge clk_in) disable iff (reset_in)
        desc_valid && !wr_w0 && !(res_take && (finished || fatal))
            |=> desc_valid)
        else $error("Valid bit cleared without cause.");

    a_cs_mask_clear: assert property (
        @(posedge clk_in) disable iff (reset_in)
        s_answer ##0 state_reg == ST_WAIT_COMPLETE |=>
            !complete_split_mask[$past(uf_reg)])
        else $error("Complete split mask bit not cleared.");

    a_count_written: assert property (
        @(posedge clk_in) disable iff (reset_in)
        s_answer ##0 ss_hit_reg |=> cnt_now == $past(res_in.bytes))
        else $error("Received byte count not stored.");

    a_count_held: assert property (
        @(posedge clk_in) disable iff (reset_in)
        res_take && !ss_hit_reg && !wr_cnt |=> $stable(cnt_now))
        else $error("Byte count written without a start split hit.");

    a_request_held: assert property (
        @(posedge clk_in) disable iff (reset_in)
        s_waiting |=> req_out.valid && $stable(req_out.len) &&
            $stable(uf_reg))
        else $error("Request dropped or changed before its answer.");

    a_result_stored: assert property (
        @(posedge clk_in) disable iff (reset_in)
        s_answer |=> desc_mem[4][`W4_RESULT_LSB + 3 * uf_reg +: 3] ==
            $past(res_in.uframe_result))
        else $error("Microframe result not recorded.");
endmodule : split_descriptor_engine
`default_nettype wire

// [test/split_link_partner.sv]
// Behavioural far side that answers each split request after a delay.
`default_nettype none
module split_link_partner
    import split_desc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire txn_req_s req_in,
    input wire logic [3:0] delay_in,
    input wire logic [2:0] result_in,
    input wire logic [7:0] bytes_in,
    output var txn_res_s res_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    logic answered;

    // One answer per request; idle result lines toggle so stale data
    // can never pass for a fresh answer.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            res_out <= '0;
            wait_cnt <= 4'h0;
            answered <= 1'b0;
        end else if (req_in.valid && !answered && wait_cnt >= delay_in) begin
            res_out <= {1'b1, result_in, bytes_in};
            answered <= 1'b1;
        end else begin
            res_out <= {1'b0, ~res_out.uframe_result, ~res_out.bytes};
            wait_cnt <= req_in.valid ? wait_cnt + 4'h1 : 4'h0;
            answered <= answered & req_in.valid;
        end
    end
endmodule : split_link_partner
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the split descriptor engine.
`default_nettype none
module tb
    import split_desc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic tick = 1'b0, active_out;
    logic [7:0] addr_in = 8'h00, pbytes = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [2:0] uframe = 3'h0, presult = 3'h0;
    logic [4:0] frame = 5'h00;
    logic [3:0] pdelay = 4'h0;
    // Model copy of the scheduler enable, so refused ticks are predicted.
    logic sched_en = 1'b0;
    txn_req_s req_out;
    txn_res_s res_in;
    logic [31:0] mem [8];
    int error_cnt = 0, total_checks = 0, seed = 32'hBADFDB94;

    split_descriptor_engine i_split_descriptor_engine (.clk_in(clk_in),
        .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .uframe_tick_in(tick), .uframe_in(uframe), .frame_in(frame),
        .req_out(req_out), .res_in(res_in), .active_out(active_out));
    split_link_partner i_split_link_partner (.clk_in(clk_in),
        .reset_in(reset_in), .req_in(req_out), .delay_in(pdelay),
        .result_in(presult), .bytes_in(pbytes), .res_out(res_in));

    // Free-running system clock.
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bus cycles; writes to descriptor words also update the model.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        if (a < 8'h20 && a[1:0] == 2'b00) mem[a[4:2]] = d;
        if (a == 8'h20) sched_en = d[0];
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, e);
    endtask : rd

    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic setup(input logic [10:0] lim, input logic [14:0] cnt,
            input logic [7:0] ssm, input logic [7:0] csm, input logic [4:0] f);
        // A random endpoint bit keeps a stuck request field visible.
        wr(8'h00, {1'($random(seed)), 2'b00, lim, cnt, 2'b00,
            1'b1});
        wr(8'h08, {8'h00, 16'($random(seed)), f, 3'b000});
        wr(8'h0C, 32'h8000_0000);
        wr(8'h10, {24'h0, ssm});
        wr(8'h14, {24'h0, csm});
        wr(8'h18, 32'h0);
        wr(8'h1C, 32'h0);
    endtask : setup

    // Predict one microframe, let the partner answer, then audit words.
    task automatic split(input int u, input logic [4:0] f,
            input logic [7:0] nb, input logic [2:0] rs);
        logic ss;
        logic cs;
        logic [14:0] left;
        int b;
        ss = sched_en && mem[0][0] && mem[4][u] && mem[2][7:3] == f;
        cs = sched_en && mem[0][0] && !ss && mem[5][u];
        left = mem[0][17:3] - 15'(mem[3][11:0]);
        @(posedge clk_in);
        tick <= 1'b1;
        uframe <= 3'(u);
        frame <= f;
        pbytes <= nb;
        presult <= rs;
        pdelay <= 4'($random(seed));
        @(posedge clk_in);
        tick <= 1'b0;
        #1;
        chk(req_out.valid, ss | cs);
        if (ss | cs) begin
            chk(req_out.complete, cs);
            chk(req_out.endpoint_low, mem[0][31]);
            chk(req_out.len, !ss ? 0 : left < mem[0][28:18] ? left
                : mem[0][28:18]);
            chk(req_out.buffer_start_pointer, mem[2][23:8]);
            for (b = 0; b < 40 && req_out.valid; b++) begin
                @(posedge clk_in);
                #1;
            end
            b = u + 1;
            mem[4][8 + 3 * u +: 3] = rs;
            mem[3][11:0] += 12'(nb);
            mem[3][27] = ss;
            if (ss) mem[5 + b / 4][8 * (b % 4) +: 8] = nb;
            if (cs) mem[5][u] = 1'b0;
            if (15'(mem[3][11:0]) >= mem[0][17:3] || rs[2]) begin
                mem[0][0] = 1'b0;
                mem[3][31] = 1'b0;
            end
        end else begin
            repeat (4) @(posedge clk_in);
            #1;
            chk(req_out.valid, 1'b0);
        end
        for (b = 0; b < 8; b++) rd(8'(4 * b), mem[b]);
        rd(8'h24, {29'h0, mem[0][0], 2'b00});
        chk(active_out, mem[0][0]);
    endtask : split

    // Main sequence: reset, map, then three descriptor runs.
    initial begin
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, 32'h0);
        rd(8'h02, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(8'(4 * i), $random(seed));
            rd(8'(4 * i), mem[i]);
        end
        $display("test map done");
        setup(11'h0BC, 15'h12C, 8'h03, 8'h04, 5'h0A);
        split(0, 5'h0A, 8'hBC, 3'h0);
        wr(8'h20, 32'h1);
        rd(8'h20, 32'h1);
        split(0, 5'h0A, 8'hBC, 3'h0);
        split(1, 5'h0A, 8'h70, 3'h0);
        split(2, 5'h0A, 8'h33, 3'h0);
        $display("test start done");
        setup(11'h032, 15'h032, 8'h01, 8'h04, 5'h15);
        split(0, 5'h03, 8'h11, 3'h0);
        split(2, 5'h03, 8'h14, 3'h1);
        split(0, 5'h15, 8'h05, 3'h4);
        $display("test complete done");
        setup(11'h0C0, 15'h3FF, 8'hFF, 8'hFF, 5'h1F);
        for (int k = 0; k < 8; k++) split(k, 5'h1F, 8'($random(seed)), 3'h0);
        $display("test sweep done");
        end_sim;
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #(25 * 20000);
        error_cnt++;
        end_sim;
    end
endmodule : tb
`default_nettype wire
